// ==== verilog/tmu_pkg.sv ====
// Package of the timing unit: register map, field layout, reset values,
// counter limits and the packed state record of the timing unit.
// Assumes an APB master with 32-bit data and word-aligned register indices.
package tmu_pkg;

    localparam int unsigned TMU_ADDR_W = 12;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h02;
    localparam logic [7:0] IDX_T1_RELOAD_LO = 8'h03;
    localparam logic [7:0] IDX_T1_RELOAD_HI = 8'h04;
    localparam logic [7:0] IDX_T2_RELOAD_LO = 8'h05;
    localparam logic [7:0] IDX_T2_RELOAD_HI = 8'h06;
    localparam logic [7:0] IDX_MODE_CTRL    = 8'h09;
    localparam logic [7:0] IDX_POWER_TB     = 8'h0a;
    localparam logic [7:0] IDX_COUNT_VIEW   = 8'h0b;

    localparam logic [TMU_ADDR_W-1:0] ADDR_IRQ_ENABLE   = {2'h0, IDX_IRQ_ENABLE, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_T1_RELOAD_LO = {2'h0, IDX_T1_RELOAD_LO, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_T1_RELOAD_HI = {2'h0, IDX_T1_RELOAD_HI, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_T2_RELOAD_LO = {2'h0, IDX_T2_RELOAD_LO, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_T2_RELOAD_HI = {2'h0, IDX_T2_RELOAD_HI, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_MODE_CTRL    = {2'h0, IDX_MODE_CTRL, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_POWER_TB     = {2'h0, IDX_POWER_TB, 2'h0};
    localparam logic [TMU_ADDR_W-1:0] ADDR_COUNT_VIEW   = {2'h0, IDX_COUNT_VIEW, 2'h0};

    // Field positions
    localparam int unsigned BIT_TIMER2_IRQ  = 1;
    localparam int unsigned BIT_TIMER1_IRQ  = 2;
    localparam int unsigned BIT_TIMER1_RUN  = 2;
    localparam int unsigned BIT_TIMER2_RUN  = 3;
    localparam int unsigned BIT_TB_ENABLE   = 4;
    localparam int unsigned TB_RATE_LSB     = 0;
    localparam int unsigned TB_RATE_W       = 4;

    // Writable masks; other bits read as zero
    localparam logic [7:0] IRQ_ENABLE_MASK  = 8'h06;
    localparam logic [7:0] MODE_CTRL_MASK   = 8'h0c;
    localparam logic [7:0] POWER_TB_MASK    = 8'h1f;

    // Values after reset, and the count at which a timer underflows
    localparam logic [7:0]  IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0]  MODE_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  POWER_TB_RESET   = 8'h00;
    localparam logic [15:0] RELOAD_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [15:0] COUNT_UNDERFLOW  = 16'h0000;

    // Watchdog fires after this many uncleared timer1 clocks
    localparam logic [15:0] WATCHDOG_LIMIT   = 16'h8000;
    localparam logic [15:0] WATCHDOG_LAST    = WATCHDOG_LIMIT - 16'h0001;

    // Timer2 drops every third system tick, giving the system rate over 1.5
    localparam logic [1:0]  T2_PHASE_DROP    = 2'h2;

    typedef struct packed {
        logic [7:0]  irq_enable;
        logic [7:0]  mode_ctrl;
        logic [7:0]  power_tb;
        logic [15:0] reload1;
        logic [15:0] reload2;
        logic [15:0] count1;
        logic [15:0] count2;
        logic [1:0]  t2_phase;
        logic [15:0] tb_count;
        logic [15:0] wd_count;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        timer1_irq;
        logic        timer2_irq;
        logic        tick_irq;
        logic        wd_reset;
    } tmu_state_t;

endpackage

// ==== verilog/tmu_timing_unit.sv ====
// Timing unit: two 16-bit auto-reload down counters, a periodic tick
// unit and a watchdog, programmed over APB with one wait state.
// Assumes slow, fast and system rates arrive as one-cycle enable pulses
// synchronous to mclk_in, and that the core decodes the watchdog clear.
`timescale 1ns/100ps

// Summary of operation
// - Timer1 is a 16-bit down counter with two write-only reload bytes.
// - While enabled, timer1 decrements by one per selected clock pulse.
// - Stepping from 0000h to FFFFh raises that timer's interrupt request.
// - On underflow timer1 reloads from its reload bytes and keeps counting.
// - Reload value N gives N+1 counter pulses between underflows.
// - Reset clears counters; first count after enable underflows and reloads.
// - Timer1 counts slow clock, or fast clock in fast-only operation.
// - Interrupt enable bit 2 gates timer1 interrupt, reset value zero.
// - Mode control bit 2 enables timer1, reset value zero.
// - Timer2 is like timer1 but counts the system clock over 1.5.
// - On underflow timer2 reloads from its own write-only reload bytes.
// - Interrupt enable bit 1 gates timer2 interrupt, reset value zero.
// - Mode control bit 3 enables timer2, reset value zero.
// - Tick unit divides slow clock by power of two from rate field.
// - Power control bit 4 enables the tick unit, reset value zero.
// - Rate code c divides slow clock by two to the power c+1.
// - Watchdog acts only when the build option enables it.
// - Watchdog counts timer1 clock, resets system after 32768 uncleared clocks.
// - Watchdog runs in normal, slow and idle; stops in sleep.
module tmu_timing_unit
    import tmu_pkg::*;
#(
    parameter bit WATCHDOG_BUILD_OPTION = 1'b1
)
(
    input  wire logic                  mclk_in,
    input  wire logic                  srst_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [TMU_ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic                       pready_out,
    output logic                       pslverr_out,
    output logic [31:0]                prdata_out,
    input  wire logic                  slow_clock_tick_in,
    input  wire logic                  fast_clock_tick_in,
    input  wire logic                  system_clock_tick_in,
    input  wire logic                  fast_only_mode_in,
    input  wire logic                  sleep_mode_in,
    input  wire logic                  watchdog_clear_instruction_in,
    output logic                       timer1_irq_out,
    output logic                       timer2_irq_out,
    output logic                       tick_irq_out,
    output logic                       watchdog_reset_out
);

    tmu_state_t state;
    tmu_state_t next_state;

    logic                  bus_access;
    logic                  bus_commit;
    logic                  addr_mapped;
    logic [7:0]            read_byte;
    logic [31:0]           read_word;
    logic                  timer1_clock;
    logic                  timer2_clock;
    logic                  slow_active;
    logic                  timer1_run;
    logic                  timer2_run;
    logic                  tb_enable;
    logic [TB_RATE_W-1:0]  tb_rate;
    logic [15:0]           tb_mask;
    logic                  tb_expire;
    logic                  t1_underflow;
    logic                  t2_underflow;
    logic                  wd_expire;

    always_comb
    begin
        next_state   = state;
        bus_access   = psel_in && penable_in;
        bus_commit   = bus_access && state.pready;
        timer1_run   = state.mode_ctrl[BIT_TIMER1_RUN];
        timer2_run   = state.mode_ctrl[BIT_TIMER2_RUN];
        tb_enable    = state.power_tb[BIT_TB_ENABLE];
        tb_rate      = state.power_tb[TB_RATE_LSB +: TB_RATE_W];

        // Register read path; write-only bytes read back as zero
        addr_mapped  = 1'b1;
        read_byte    = 8'h00;
        read_word    = 32'h0000_0000;
        case (paddr_in)
            ADDR_IRQ_ENABLE:
            begin
                read_byte = state.irq_enable;
            end
            ADDR_MODE_CTRL:
            begin
                read_byte = state.mode_ctrl;
            end
            ADDR_POWER_TB:
            begin
                read_byte = state.power_tb;
            end
            ADDR_T1_RELOAD_LO, ADDR_T1_RELOAD_HI, ADDR_T2_RELOAD_LO, ADDR_T2_RELOAD_HI:
            begin
                read_byte = 8'h00;
            end
            ADDR_COUNT_VIEW:
            begin
                read_byte = 8'h00;
            end
            default:
            begin
                addr_mapped = 1'b0;
            end
        endcase
        if (paddr_in == ADDR_COUNT_VIEW)
        begin
            read_word = {state.count2, state.count1};
        end
        else
        begin
            read_word = {24'h00_0000, read_byte};
        end

        // One wait state so that the answer comes from flip-flops
        next_state.pready  = bus_access && !state.pready;
        next_state.pslverr = bus_access && !state.pready && !addr_mapped;
        if (bus_access && !state.pready)
        begin
            next_state.prdata = pwrite_in ? 32'h0000_0000 : read_word;
        end

        if (bus_commit && pwrite_in)
        begin
            case (paddr_in)
                ADDR_IRQ_ENABLE:
                begin
                    next_state.irq_enable = pwdata_in[7:0] & IRQ_ENABLE_MASK;
                end
                ADDR_MODE_CTRL:
                begin
                    next_state.mode_ctrl = pwdata_in[7:0] & MODE_CTRL_MASK;
                end
                ADDR_POWER_TB:
                begin
                    next_state.power_tb = pwdata_in[7:0] & POWER_TB_MASK;
                end
                ADDR_T1_RELOAD_LO:
                begin
                    next_state.reload1[7:0] = pwdata_in[7:0];
                end
                ADDR_T1_RELOAD_HI:
                begin
                    next_state.reload1[15:8] = pwdata_in[7:0];
                end
                ADDR_T2_RELOAD_LO:
                begin
                    next_state.reload2[7:0] = pwdata_in[7:0];
                end
                ADDR_T2_RELOAD_HI:
                begin
                    next_state.reload2[15:8] = pwdata_in[7:0];
                end
                default:
                begin
                    next_state.reload1 = state.reload1;
                end
            endcase
        end

        // Sleep stops the slow and fast sources, so everything on them halts
        slow_active  = !sleep_mode_in;
        timer1_clock = slow_active
                       && (fast_only_mode_in ? fast_clock_tick_in : slow_clock_tick_in);

        // Drop one pulse in three to divide the system rate by 1.5
        timer2_clock = 1'b0;
        if (system_clock_tick_in)
        begin
            timer2_clock = (state.t2_phase != T2_PHASE_DROP);
            if (state.t2_phase == T2_PHASE_DROP)
            begin
                next_state.t2_phase = 2'h0;
            end
            else
            begin
                next_state.t2_phase = state.t2_phase + 2'h1;
            end
        end

        // Timer1: a zero count steps to FFFFh, which is taken as reload at once
        t1_underflow = timer1_clock && timer1_run && (state.count1 == COUNT_UNDERFLOW);
        if (timer1_clock && timer1_run)
        begin
            if (t1_underflow)
            begin
                next_state.count1 = state.reload1;
            end
            else
            begin
                next_state.count1 = state.count1 - 16'h0001;
            end
        end
        // A stopped timer keeps its count
        else
        begin
            next_state.count1 = state.count1;
        end

        t2_underflow = timer2_clock && timer2_run && (state.count2 == COUNT_UNDERFLOW);
        if (timer2_clock && timer2_run)
        begin
            if (t2_underflow)
            begin
                next_state.count2 = state.reload2;
            end
            else
            begin
                next_state.count2 = state.count2 - 16'h0001;
            end
        end
        else
        begin
            next_state.count2 = state.count2;
        end

        // Tick unit: expiry when the low c+1 bits of the prescaler are all ones
        tb_mask   = 16'((17'h0_0001 << ({1'b0, tb_rate} + 5'h01)) - 17'h0_0001);
        tb_expire = tb_enable && slow_active && slow_clock_tick_in
                    && ((state.tb_count & tb_mask) == tb_mask);
        if (!tb_enable)
        begin
            next_state.tb_count = 16'h0000;
        end
        else if (slow_active && slow_clock_tick_in)
        begin
            next_state.tb_count = state.tb_count + 16'h0001;
        end

        // Watchdog shares the timer1 clock; the clear instruction wins over a tick
        wd_expire = WATCHDOG_BUILD_OPTION && timer1_clock
                    && !watchdog_clear_instruction_in
                    && (state.wd_count == WATCHDOG_LAST);
        if (!WATCHDOG_BUILD_OPTION || watchdog_clear_instruction_in || wd_expire)
        begin
            next_state.wd_count = 16'h0000;
        end
        else if (timer1_clock)
        begin
            next_state.wd_count = state.wd_count + 16'h0001;
        end

        // Interrupt requests are single-cycle pulses
        next_state.timer1_irq = t1_underflow && state.irq_enable[BIT_TIMER1_IRQ];
        next_state.timer2_irq = t2_underflow && state.irq_enable[BIT_TIMER2_IRQ];
        next_state.tick_irq   = tb_expire;
        next_state.wd_reset   = wd_expire;
    end

    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            state            <= '0;
            state.irq_enable <= IRQ_ENABLE_RESET;
            state.mode_ctrl  <= MODE_CTRL_RESET;
            state.power_tb   <= POWER_TB_RESET;
            state.reload1    <= RELOAD_RESET;
            state.reload2    <= RELOAD_RESET;
            state.count1     <= COUNT_RESET;
            state.count2     <= COUNT_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pready_out         = state.pready;
    assign pslverr_out        = state.pslverr;
    assign prdata_out         = state.prdata;
    assign timer1_irq_out     = state.timer1_irq;
    assign timer2_irq_out     = state.timer2_irq;
    assign tick_irq_out       = state.tick_irq;
    assign watchdog_reset_out = state.wd_reset;

endmodule

// ==== bench/tmu_timing_unit_monitor.sv ====
// Checker of the timing unit ports: APB wait state and interrupt causes.
// Assumes tick inputs are one-cycle pulses at least two cycles apart.
`timescale 1ns/100ps
module tmu_timing_unit_monitor
    import tmu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic slow_clock_tick_in,
    input wire logic fast_clock_tick_in,
    input wire logic system_clock_tick_in,
    input wire logic fast_only_mode_in,
    input wire logic sleep_mode_in,
    input wire logic watchdog_clear_instruction_in,
    input wire logic timer1_irq_out,
    input wire logic timer2_irq_out,
    input wire logic tick_irq_out,
    input wire logic watchdog_reset_out
);
    logic t1_tick;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    // Sleep stops the timer1 clock, so the watchdog stops with it
    assign t1_tick = !sleep_mode_in &&
                     (fast_only_mode_in ? fast_clock_tick_in : slow_clock_tick_in);

    a_one_wait_state: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
        else $error("apb wait state wrong");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_error_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    a_t1_irq_cause: assert property (timer1_irq_out |-> $past(t1_tick))
        else $error("timer1 irq without its clock");
    a_t1_irq_single: assert property (timer1_irq_out |=> !timer1_irq_out)
        else $error("timer1 irq longer than one cycle");
    a_t2_irq_cause: assert property (timer2_irq_out |-> $past(system_clock_tick_in))
        else $error("timer2 irq without system tick");
    a_tick_cause: assert property (tick_irq_out |-> $past(slow_clock_tick_in && !sleep_mode_in))
        else $error("tick irq without slow tick");
    a_wdog_cause: assert property (watchdog_reset_out |-> $past(t1_tick && !watchdog_clear_instruction_in))
        else $error("watchdog reset without uncleared tick");

    cover property (timer1_irq_out);
    cover property (timer2_irq_out);
    cover property (tick_irq_out);
    cover property (watchdog_reset_out);
endmodule
bind tmu_timing_unit tmu_timing_unit_monitor tmu_timing_unit_monitor_i (.*);

// ==== bench/tmu_clock_source_model.sv ====
// Clock source model: slow, fast and system clock edges as one-cycle
// pulses. Assumes periods of two cycles or more; zero stops a lane.
`timescale 1ns/100ps
module tmu_clock_source_model
    import tmu_pkg::*;
(
    input  wire logic            mclk_in,
    input  wire logic            srst_in,
    input  wire logic [2:0][7:0] period_in,
    output logic      [2:0]      tick_out
);
    logic [2:0][7:0] phase;

    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < 3; i++)
        begin
            tick_out[i] <= !srst_in && period_in[i] != 8'h00 &&
                           phase[i] + 8'h01 >= period_in[i];
            phase[i] <= (srst_in || phase[i] + 8'h01 >= period_in[i]) ? 8'h00 : phase[i] + 8'h01;
        end
    end
endmodule

// ==== bench/testbench.sv ====
// Testbench of the timing unit: APB software, clock source model and
// a counting model of interrupt spacing. Assumes the watchdog is built in.
`timescale 1ns/100ps
module testbench
    import tmu_pkg::*;
;
    logic                  mclk_in, srst_in, psel_in, penable_in, pwrite_in, err, feed;
    logic [TMU_ADDR_W-1:0] paddr_in;
    logic [31:0]           pwdata_in, prdata_out, rd, x, lfsr;
    logic                  pready_out, pslverr_out, fast_only_mode_in, sleep_mode_in;
    logic                  watchdog_clear_instruction_in, timer1_irq_out, timer2_irq_out;
    logic                  tick_irq_out, watchdog_reset_out, sel, st, yt;
    logic                  slow_clock_tick_in, fast_clock_tick_in, system_clock_tick_in;
    logic [2:0][7:0]       period;
    bit                    run1 = 0, run2 = 0;
    int                    mismatches = 0, tests_run = 0, cyc = 0, nv, mv, k;
    int                    n1 = 0, n2 = 0, nt = 0, nw = 0, g1 = 0, g2 = 0, gt = 0, gw = 0;
    int                    c1 = 0, c2 = 0, ct = 0, cw = 0;

    tmu_timing_unit tmu_timing_unit_i (.*);
    tmu_clock_source_model tmu_clock_source_model_i
    (
        .mclk_in,
        .srst_in,
        .period_in (period),
        .tick_out  ({system_clock_tick_in, fast_clock_tick_in, slow_clock_tick_in})
    );

    assign st = slow_clock_tick_in && !sleep_mode_in;
    assign yt = system_clock_tick_in;
    assign sel = fast_only_mode_in ? fast_clock_tick_in && !sleep_mode_in : st;

    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reference: ticks counted between pulses; a clear beats a tick
    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        watchdog_clear_instruction_in <= feed && cyc % 400 == 0;
        n1 <= !run1 ? 0 : timer1_irq_out ? int'(sel) : n1 + sel;
        n2 <= !run2 ? 0 : timer2_irq_out ? int'(yt) : n2 + yt;
        nt <= tick_irq_out ? int'(st) : nt + st;
        nw <= watchdog_clear_instruction_in ? 0 : watchdog_reset_out ? int'(sel) : nw + sel;
        g1 <= timer1_irq_out ? n1 : g1;
        g2 <= timer2_irq_out ? n2 : g2;
        gt <= tick_irq_out ? nt : gt;
        gw <= watchdog_reset_out ? nw : gw;
        c1 <= c1 + timer1_irq_out;
        c2 <= c2 + timer2_irq_out;
        ct <= ct + tick_irq_out;
        cw <= cw + watchdog_reset_out;
        if (cyc == 90000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        // An idle edge first keeps the last release and this setup apart
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        @(posedge mclk_in);
        while (pready_out !== 1'b1)
            @(posedge mclk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic wt(ref int c, input int v);
        while (c < v)
            @(posedge mclk_in);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        {psel_in, penable_in, pwrite_in, fast_only_mode_in, sleep_mode_in} = '0;
        paddr_in = '0;
        pwdata_in = '0;
        period = '0;
        srst_in = 1'b1;
        feed = 1'b1;
        lfsr = lf(32'h3528);
        repeat (20) @(posedge mclk_in);
        srst_in <= 1'b0;
        period <= {8'h02, 8'h03, 8'h04};
        @(posedge mclk_in);
        rdc(ADDR_IRQ_ENABLE, 32'h0);
        rdc(ADDR_MODE_CTRL, 32'h0);
        rdc(ADDR_POWER_TB, 32'h0);
        rdc(ADDR_COUNT_VIEW, 32'h0);
        apb(1'b0, 12'hffc, 32'h0);
        chk(err, 1'b1);
        $display("test reset_map done");
        nv = lfsr[2:0] + 1;
        mv = 256 + {lfsr[5:4], 1'b1};
        apb(1'b1, ADDR_T1_RELOAD_LO, nv);
        apb(1'b1, ADDR_T1_RELOAD_HI, 32'h0);
        rdc(ADDR_T1_RELOAD_LO, 32'h0);
        apb(1'b1, ADDR_T2_RELOAD_LO, mv % 256);
        apb(1'b1, ADDR_T2_RELOAD_HI, 32'h1);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h6);
        rdc(ADDR_IRQ_ENABLE, 32'h6);
        apb(1'b1, ADDR_MODE_CTRL, 32'hc);
        run1 <= 1'b1;
        run2 <= 1'b1;
        rdc(ADDR_MODE_CTRL, 32'hc);
        wt(c1, 1);
        chk(g1, 1);
        wt(c1, 3);
        chk(g1, nv + 1);
        wt(c2, 3);
        chk(g2, 3 * (mv + 1) / 2);
        $display("test reload done");
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge mclk_in);
        k = c1 + c2;
        repeat (300) @(posedge mclk_in);
        chk(c1 + c2, k);
        apb(1'b1, ADDR_MODE_CTRL, 32'h0);
        run1 <= 1'b0;
        apb(1'b0, ADDR_COUNT_VIEW, 32'h0);
        x = rd;
        repeat (100) @(posedge mclk_in);
        rdc(ADDR_COUNT_VIEW, x);
        $display("test gate_hold done");
        fast_only_mode_in <= 1'b1;
        period <= {8'h02, 8'h03, 8'h00};
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h4);
        apb(1'b1, ADDR_MODE_CTRL, 32'h4);
        run1 <= 1'b1;
        k = c1;
        wt(c1, k + 3);
        chk(g1, nv + 1);
        fast_only_mode_in <= 1'b0;
        period <= {8'h02, 8'h03, 8'h04};
        chk(ct, 0);
        for (int c = 0; c < 7; c++)
        begin
            apb(1'b1, ADDR_POWER_TB, 32'h10 | c);
            k = ct;
            wt(ct, k + 3);
            chk(gt, 2 ** (c + 1));
        end
        $display("test fast_tick done");
        sleep_mode_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        k = c1 + ct;
        repeat (300) @(posedge mclk_in);
        chk(c1 + ct, k);
        sleep_mode_in <= 1'b0;
        fast_only_mode_in <= 1'b1;
        period <= {8'h02, 8'h02, 8'h00};
        feed <= 1'b0;
        wt(cw, 1);
        chk(gw, 32768);
        $display("test sleep_watchdog done");
        end_of_test();
    end
endmodule
